// *** rba_core.sv ***
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module rba_core
  import rba_pkg::*;
#(
  parameter int ELEM_BYTES = 2,
  parameter int ELEM_SHIFT = 16,
  parameter logic [31:0] SUPPORTED_MASK = 32'h0000ffff
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // media lookup, answered combinationally on the same clock
  output logic [31:0] lba_query,
  output logic query_valid,
  input wire logic media_pred_err,
  input wire logic media_unpred_err,
  // status
  output logic mode_on,
  output logic irq
);
  localparam int EB = 8 * ELEM_BYTES;
  localparam int EIDX_W = (EB > 1) ? $clog2(EB) : 1;
  localparam logic [EB-1:0] SUP = SUPPORTED_MASK[EB-1:0];
  localparam logic [7:0] N = 8'(ELEM_BYTES);

  rba_state_e state_reg;
  rba_sense_s sense_reg;
  logic ack_reg;
  logic [31:0] lba_reg, cnt_reg, cur_reg, remain_reg, first_reg, last_reg;
  logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
  logic [EB-1:0] stage_map_reg, active_map_reg;
  logic mode_reg;
  logic [7:0] page_idx_reg, page_byte;
  logic [31:0] bm, rd_mux;
  logic wr_fire, rd_fire, go, page_wr;
  logic [EIDX_W-1:0] eidx;
  logic elem_dis, pred_hit, any_err, fin_good, fin_unpred, fin_run;
  logic pg_en, pg_bad_len, pg_bad_map, pg_reject;
  logic [7:0] pg_len;
  logic [EB-1:0] pg_map;

  // bus handshake: one wait cycle, then the answer; write lands at that edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_fire = ce & avs_write & ack_reg;
  assign rd_fire = ce & avs_read & ack_reg;
  assign bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // ack toggles so back-to-back requests each see one wait cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      ack_reg <= 1'b0;
    else if (ce)
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  // strobes decoded from the write that lands this cycle
  assign go = wr_fire && avs_address == OFF_CTRL && avs_byteenable[0]
              && avs_writedata[CTRL_GO_BIT] && state_reg == ST_IDLE;
  assign page_wr = wr_fire && avs_address == OFF_PAGE_CTRL
                   && avs_byteenable[0] && state_reg == ST_IDLE;
  assign pg_en = avs_writedata[PCTRL_EN_BIT];
  assign pg_len = avs_writedata[PCTRL_LEN_LSB +: 8];
  assign pg_map = stage_map_reg;

  // output page checks; a disabled page skips them all
  assign pg_bad_len = pg_len != N;
  assign pg_bad_map = (|(pg_map & ~SUP))
                      || ((pg_map & SUP) == SUP)
                      || (|(active_map_reg & ~pg_map));
  assign pg_reject = page_wr && pg_en && (pg_bad_len || pg_bad_map);

  // rebuild-assist mode and the set of disabled elements
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_reg <= 1'b0;
      active_map_reg <= '0;
    end
    else if (ce && page_wr)
    begin
      if (!pg_en)
      begin
        mode_reg <= 1'b0;
        active_map_reg <= '0;
      end
      else if (!pg_reject)
      begin
        mode_reg <= 1'b1;
        active_map_reg <= pg_map;
      end
    end
  end
  assign mode_on = mode_reg;

  // software-written registers, honouring byte enables, except that a mask write without byte 0 clears the mask
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lba_reg <= RST_LBA;
      cnt_reg <= RST_CNT;
      irq_mask_reg <= RST_IRQ_MASK;
      stage_map_reg <= '0;
    end
    else if (wr_fire)
    begin
      if (avs_address == OFF_LBA)
        lba_reg <= (lba_reg & ~bm) | (avs_writedata & bm);
      else if (avs_address == OFF_CNT)
        cnt_reg <= (cnt_reg & ~bm) | (avs_writedata & bm);
      else if (avs_address == OFF_IRQ_MASK)
        irq_mask_reg <= avs_writedata[IRQ_W-1:0] & bm[IRQ_W-1:0];
      else if (avs_address == OFF_PAGE_MAP)
        stage_map_reg <= (stage_map_reg & ~bm[EB-1:0])
                         | (avs_writedata[EB-1:0] & bm[EB-1:0]);
    end
  end

  // page byte pointer; each data read steps it so software can stream
  always_ff @(posedge clk)
  begin
    if (reset)
      page_idx_reg <= RST_PAGE_IDX;
    else if (wr_fire && avs_address == OFF_PAGE_IDX && avs_byteenable[0])
      page_idx_reg <= avs_writedata[7:0];
    else if (rd_fire && avs_address == OFF_PAGE_DATA)
      page_idx_reg <= page_idx_reg + 8'h01;
  end

  rba_page_byte #(.ELEM_BYTES(ELEM_BYTES)) u_page (
    .mode_on(mode_reg),
    .mask(SUP),
    .map(active_map_reg),
    .idx(page_idx_reg),
    .byte_out(page_byte)
  );

  // read decode; unmapped offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0;
    if (avs_address == OFF_CTRL)
      rd_mux = {31'h0, state_reg != ST_IDLE};
    else if (avs_address == OFF_LBA)
      rd_mux = lba_reg;
    else if (avs_address == OFF_CNT)
      rd_mux = cnt_reg;
    else if (avs_address == OFF_STAT)
      rd_mux = {sense_reg.ascq, sense_reg.asc, 4'h0, sense_reg.key, 5'h00,
                mode_reg, sense_reg.check, state_reg != ST_IDLE};
    else if (avs_address == OFF_INFO)
      rd_mux = sense_reg.info;
    else if (avs_address == OFF_CSI)
      rd_mux = sense_reg.csi;
    else if (avs_address == OFF_IRQ_STAT)
      rd_mux = {{(32-IRQ_W){1'b0}}, irq_stat_reg};
    else if (avs_address == OFF_IRQ_MASK)
      rd_mux = {{(32-IRQ_W){1'b0}}, irq_mask_reg};
    else if (avs_address == OFF_PAGE_CTRL)
      rd_mux = {16'h0, N, 7'h00, mode_reg};
    else if (avs_address == OFF_PAGE_MAP)
      rd_mux = 32'(stage_map_reg);
    else if (avs_address == OFF_PAGE_IDX)
      rd_mux = {24'h0, page_idx_reg};
    else if (avs_address == OFF_PAGE_DATA)
      rd_mux = {24'h0, page_byte};
    else if (avs_address == OFF_ACTIVE_MAP)
      rd_mux = 32'(active_map_reg);
  end

  // read data is caught in the wait cycle and stands in the answer cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      avs_readdata <= 32'h0;
    else if (ce && avs_read && !ack_reg)
      avs_readdata <= rd_mux;
  end

  // element of the current LBA and the verdict on it
  assign eidx = cur_reg[ELEM_SHIFT +: EIDX_W];
  assign elem_dis = (32'(eidx) < 32'(EB)) && active_map_reg[eidx];
  assign pred_hit = mode_reg && (media_pred_err || elem_dis);
  assign any_err = pred_hit || media_unpred_err;
  assign query_valid = state_reg != ST_IDLE;
  assign lba_query = cur_reg;

  // how the scan ends this cycle
  assign fin_unpred = state_reg == ST_SCAN && !pred_hit && media_unpred_err;
  assign fin_good = state_reg == ST_SCAN && !any_err && remain_reg == 32'h1;
  // a run also stops at the top of the address space rather than wrap
  assign fin_run = state_reg == ST_RUN
                   && (!any_err || cur_reg == 32'hffffffff);

  // read scan: one LBA a cycle, then follow the bad run past its start
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      cur_reg <= 32'h0;
      remain_reg <= 32'h0;
      first_reg <= 32'h0;
      last_reg <= 32'h0;
    end
    else if (ce)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (go && cnt_reg != 32'h0)
          begin
            cur_reg <= lba_reg;
            remain_reg <= cnt_reg;
            state_reg <= ST_SCAN;
          end
        end
        ST_SCAN:
        begin
          if (pred_hit)
          begin
            first_reg <= cur_reg;
            last_reg <= cur_reg;
            cur_reg <= cur_reg + 32'h1;
            state_reg <= ST_RUN;
          end
          else if (fin_unpred || fin_good)
            state_reg <= ST_IDLE;
          else
          begin
            cur_reg <= cur_reg + 32'h1;
            remain_reg <= remain_reg - 32'h1;
          end
        end
        ST_RUN:
        begin
          if (any_err)
            last_reg <= cur_reg;
          if (fin_run)
            state_reg <= ST_IDLE;
          else
            cur_reg <= cur_reg + 32'h1;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // sense data of the last command, read or output page
  always_ff @(posedge clk)
  begin
    if (reset)
      sense_reg <= RST_SENSE;
    else if (ce)
    begin
      if (fin_run)
        sense_reg <= '{1'b1, SK_ABORTED, ASC_READ_ERR, ASCQ_MULTI,
                       first_reg, any_err ? cur_reg : last_reg};
      else if (fin_unpred)
        sense_reg <= '{1'b1, SK_MEDIUM, ASC_READ_ERR, ASC_NONE,
                       cur_reg, 32'h0};
      else if (fin_good || (go && cnt_reg == 32'h0))
        sense_reg <= RST_SENSE;
      else if (pg_reject)
        sense_reg <= '{1'b1, SK_ILLEGAL, ASC_BAD_PARAM, ASC_NONE,
                       32'h0, 32'h0};
      else if (page_wr)
        sense_reg <= RST_SENSE;
    end
  end

  // sticky events, cleared by writing one; a new event beats the clear
  assign irq_ev[IRQ_DONE] = fin_run || fin_unpred || fin_good
                            || (go && cnt_reg == 32'h0);
  assign irq_ev[IRQ_CHECK] = fin_run || fin_unpred || pg_reject;
  assign irq_ev[IRQ_REJECT] = pg_reject;
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_stat_reg <= '0;
    else if (ce)
    begin
      if (wr_fire && avs_address == OFF_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~(avs_writedata[IRQ_W-1:0]
                         & bm[IRQ_W-1:0])) | irq_ev;
      else
        irq_stat_reg <= irq_stat_reg | irq_ev;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_abort_key;
    ce && fin_run |=> sense_reg.key == SK_ABORTED
      && sense_reg.asc == ASC_READ_ERR && sense_reg.ascq == ASCQ_MULTI;
  endproperty
  a_abort_key: assert property (p_abort_key)
    else $error("aborted run has wrong sense code");

  // first bad lba is caught at the hit, then carried to the sense field
  property p_info_first;
    (ce && state_reg == ST_SCAN && pred_hit |=> first_reg == $past(cur_reg))
    and (ce && fin_run |=> sense_reg.info == $past(first_reg));
  endproperty
  a_info_first: assert property (p_info_first)
    else $error("information field is not first bad lba");

  property p_csi_last;
    ce && fin_run && !any_err |=> sense_reg.csi == $past(cur_reg) - 32'h1;
  endproperty
  a_csi_last: assert property (p_csi_last)
    else $error("command-specific field is not end of run");

  property p_good_done;
    ce && fin_good |=> !sense_reg.check && irq_stat_reg[IRQ_DONE]
      && state_reg == ST_IDLE;
  endproperty
  a_good_done: assert property (p_good_done)
    else $error("clean read did not complete good");

  property p_no_pred_off;
    !mode_reg |-> !pred_hit && state_reg != ST_RUN;
  endproperty
  a_no_pred_off: assert property (p_no_pred_off)
    else $error("predicted error while mode is off");

  property p_unpred;
    ce && state_reg == ST_SCAN && media_unpred_err && !pred_hit
      |=> sense_reg.key == SK_MEDIUM && sense_reg.info == $past(cur_reg);
  endproperty
  a_unpred: assert property (p_unpred)
    else $error("unpredicted error not reported");

  property p_page_hdr;
    (page_idx_reg == 8'h00 |-> page_byte == PAGE_CODE)
    and (page_idx_reg == IDX_LEN_LSB |-> page_byte == 8'(4 + 2*ELEM_BYTES))
    and (page_idx_reg == IDX_ELEM_LEN |-> page_byte == N);
  endproperty
  a_page_hdr: assert property (p_page_hdr)
    else $error("page header byte wrong");

  property p_page_mask;
    page_idx_reg == PAGE_HDR_BYTES |-> page_byte == SUP[EB-1 -: 8];
  endproperty
  a_page_mask: assert property (p_page_mask)
    else $error("mask does not start at byte 8 msb first");

  property p_enabled_bit;
    page_idx_reg == IDX_ENABLED |-> page_byte == {7'h00, mode_reg};
  endproperty
  a_enabled_bit: assert property (p_enabled_bit)
    else $error("enabled bit does not follow mode");

  property p_supported;
    (active_map_reg & ~SUP) == '0;
  endproperty
  a_supported: assert property (p_supported)
    else $error("unsupported element disabled");

  property p_elem_pred;
    mode_reg && elem_dis && query_valid |-> pred_hit;
  endproperty
  a_elem_pred: assert property (p_elem_pred)
    else $error("disabled element gave no predicted error");

  property p_disable_page;
    ce && page_wr && !pg_en |=> !mode_reg && active_map_reg == '0
      && !irq_stat_reg[IRQ_REJECT] || $past(irq_stat_reg[IRQ_REJECT]);
  endproperty
  a_disable_page: assert property (p_disable_page)
    else $error("disable page did not clear mode");

  property p_bad_len;
    ce && page_wr && pg_en && pg_bad_len |=> sense_reg.key == SK_ILLEGAL
      && irq_stat_reg[IRQ_REJECT] && $stable(active_map_reg)
      && $stable(mode_reg);
  endproperty
  a_bad_len: assert property (p_bad_len)
    else $error("length mismatch not refused");

  property p_reserved;
    page_idx_reg == 8'h01 || page_idx_reg == 8'h05 || page_idx_reg == 8'h06
      |-> page_byte == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved page byte not zero");

  c_run: cover property (ce && fin_run && state_reg == ST_RUN);
  c_unpred: cover property (ce && fin_unpred);
  c_reject: cover property (ce && pg_reject);
  c_good: cover property (ce && fin_good ##1 irq);
endmodule // rba_core
`default_nettype wire

// *** rba_pkg.sv ***
`default_nettype none
package rba_pkg;
  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LBA = 8'h04;
  localparam logic [7:0] OFF_CNT = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_INFO = 8'h10;
  localparam logic [7:0] OFF_CSI = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFF_PAGE_CTRL = 8'h20;
  localparam logic [7:0] OFF_PAGE_MAP = 8'h24;
  localparam logic [7:0] OFF_PAGE_IDX = 8'h28;
  localparam logic [7:0] OFF_PAGE_DATA = 8'h2c;
  localparam logic [7:0] OFF_ACTIVE_MAP = 8'h30;
  // field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int PCTRL_EN_BIT = 0;
  localparam int PCTRL_LEN_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_CHECK = 1;
  localparam int IRQ_REJECT = 2;
  localparam int IRQ_W = 3;
  // input page layout
  localparam logic [7:0] PAGE_CODE = 8'h42;
  localparam logic [7:0] PAGE_LEN_BASE = 8'h04;
  localparam logic [7:0] PAGE_HDR_BYTES = 8'h08;
  localparam logic [7:0] IDX_LEN_MSB = 8'h02;
  localparam logic [7:0] IDX_LEN_LSB = 8'h03;
  localparam logic [7:0] IDX_ENABLED = 8'h04;
  localparam logic [7:0] IDX_ELEM_LEN = 8'h07;
  // sense keys and additional sense codes
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_MEDIUM = 4'h3;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_ABORTED = 4'hb;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_READ_ERR = 8'h11;
  localparam logic [7:0] ASCQ_MULTI = 8'h03;
  localparam logic [7:0] ASC_BAD_PARAM = 8'h26;
  // values after reset
  localparam logic [31:0] RST_LBA = 32'h0;
  localparam logic [31:0] RST_CNT = 32'h1;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;
  localparam logic [7:0] RST_PAGE_IDX = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SCAN = 3'h2,
    ST_RUN = 3'h4
  } rba_state_e;

  // outcome of the last command, as fixed-format sense fields
  typedef struct packed {
    logic check;
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [31:0] info;
    logic [31:0] csi;
  } rba_sense_s;

  localparam rba_sense_s RST_SENSE = '{1'b0, SK_NONE, ASC_NONE, ASC_NONE,
                                       32'h0, 32'h0};
endpackage
`default_nettype wire

// *** rba_page_byte.sv ***
`timescale 1ns/1ps
`default_nettype none
module rba_page_byte
  import rba_pkg::*;
#(
  parameter int ELEM_BYTES = 2
)
(
  // page contents
  input wire logic mode_on,
  input wire logic [8*ELEM_BYTES-1:0] mask,
  input wire logic [8*ELEM_BYTES-1:0] map,
  // byte select and byte out
  input wire logic [7:0] idx,
  output logic [7:0] byte_out
);
  localparam logic [7:0] N = 8'(ELEM_BYTES);
  localparam logic [15:0] PLEN = 16'(PAGE_LEN_BASE) + 16'(2 * ELEM_BYTES);

  // builds one byte of the input page; reserved bytes fall to zero
  always_comb
  begin
    byte_out = 8'h00;
    if (idx == 8'h00)
      byte_out = PAGE_CODE;
    else if (idx == IDX_LEN_MSB)
      byte_out = PLEN[15:8];
    else if (idx == IDX_LEN_LSB)
      byte_out = PLEN[7:0];
    else if (idx == IDX_ENABLED)
      byte_out = {7'h00, mode_on};
    else if (idx == IDX_ELEM_LEN)
      byte_out = N;
    else if (idx >= PAGE_HDR_BYTES && idx < PAGE_HDR_BYTES + N)
      // mask goes out most significant byte first
      byte_out = mask[8*(ELEM_BYTES-1-int'(idx-PAGE_HDR_BYTES)) +: 8];
    else if (idx >= PAGE_HDR_BYTES + N && idx < PAGE_HDR_BYTES + 2*N)
      byte_out = map[8*(ELEM_BYTES-1-int'(idx-PAGE_HDR_BYTES-N)) +: 8];
  end
endmodule // rba_page_byte
`default_nettype wire

// *** rba_media_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rba_media_model
(
  // clock
  input wire logic clk,
  // lookup from the core
  input wire logic [31:0] lba_query,
  input wire logic query_valid,
  output logic media_pred_err,
  output logic media_unpred_err,
  // defect layout chosen by the bench
  input wire logic [31:0] pred_lo,
  input wire logic [31:0] pred_hi,
  input wire logic [31:0] unpred_at
);
  logic junk_reg = 1'b0;
  // toggles every cycle so a core that looks outside a scan sees noise
  always @(posedge clk)
    junk_reg <= ~junk_reg;
  // predicted range wins; an unpredicted block sits outside it
  always_comb
    if (query_valid)
    begin
      media_pred_err = (lba_query >= pred_lo) && (lba_query <= pred_hi);
      media_unpred_err = (lba_query == unpred_at) && !media_pred_err;
    end
    else
    begin
      media_pred_err = junk_reg;
      media_unpred_err = ~junk_reg;
    end
endmodule // rba_media_model
`default_nettype wire

// *** tb_rebuild_assist_reporting.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_rebuild_assist_reporting;
  import rba_pkg::*;
  localparam logic [31:0] SUP = 32'h0000ffff;
  localparam logic [7:0] NB = 8'h02;
  logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic ce = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, lba_query;
  logic [31:0] pred_lo = 32'd100, pred_hi = 32'd102, unpred_at = 32'hffff0000;
  logic avs_waitrequest, query_valid, media_pred_err, media_unpred_err;
  logic mode_on, irq;
  logic [31:0] rd;
  int miscompares = 0, total_checks = 0, cycles = 0;
  rba_core #(.ELEM_BYTES(2), .ELEM_SHIFT(4), .SUPPORTED_MASK(SUP)) uut (
    .clk(clk), .reset(reset), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lba_query(lba_query), .query_valid(query_valid),
    .media_pred_err(media_pred_err), .media_unpred_err(media_unpred_err),
    .mode_on(mode_on), .irq(irq));
  rba_media_model media (
    .clk(clk), .lba_query(lba_query), .query_valid(query_valid),
    .media_pred_err(media_pred_err), .media_unpred_err(media_unpred_err),
    .pred_lo(pred_lo), .pred_hi(pred_hi), .unpred_at(unpred_at));
  // 100 MHz clock
  initial
    forever #5 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a hung handshake ends here instead of spinning forever
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until an edge sees waitrequest low, then one idle edge;
  // values read right after the edge are still the pre-edge ones
  task automatic bus_op(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    logic w;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
    end while (w !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_op(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus_op(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask
  function automatic logic [7:0] page_exp(int i, logic m, logic [15:0] mp);
    case (i)
      0: page_exp = 8'h42;
      3: page_exp = 8'h04 + NB + NB;
      4: page_exp = {7'h0, m};
      7: page_exp = NB;
      8: page_exp = SUP[15:8];
      9: page_exp = SUP[7:0];
      10: page_exp = mp[15:8];
      11: page_exp = mp[7:0];
      default: page_exp = 8'h00;
    endcase
  endfunction
  // walks the whole input page plus one byte beyond its end
  task automatic page_check(input logic m, input logic [15:0] mp);
    bw(OFF_PAGE_IDX, 32'h0);
    for (int i = 0; i < 13; i++)
      rchk(OFF_PAGE_DATA, {24'h0, page_exp(i, m, mp)});
  endtask
  // clears old events, runs one read, waits for it to finish
  task automatic scan(input logic [31:0] s, input logic [31:0] c);
    int n;
    bw(OFF_IRQ_STAT, 32'h7);
    bw(OFF_LBA, s);
    bw(OFF_CNT, c);
    bw(OFF_CTRL, 32'h1);
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 100)
    begin
      bus_op(1'b0, OFF_STAT, 32'h0, rd);
      n++;
    end
    check({31'h0, rd[0]}, 32'h0);
  endtask
  task automatic sense(input logic [3:0] k, input logic [7:0] a,
                       input logic [7:0] q, input logic [31:0] inf,
                       input logic [31:0] cs);
    bus_op(1'b0, OFF_STAT, 32'h0, rd);
    check({11'h0, rd[31:16], rd[11:8], rd[1]},
          {11'h0, q, a, k, k != SK_NONE});
    rchk(OFF_INFO, inf);
    rchk(OFF_CSI, cs);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rchk(OFF_IRQ_MASK, 32'h0);
    rchk(OFF_LBA, 32'h0);
    rchk(OFF_CNT, 32'h1);
    rchk(OFF_STAT, 32'h0);
    bw(8'h3c, 32'hffffffff);
    rchk(8'h3c, 32'h0);
    page_check(1'b0, 16'h0);
    scan(32'd98, 32'd4);
    sense(SK_NONE, 8'h00, 8'h00, 32'h0, 32'h0);
    rchk(OFF_IRQ_STAT, 32'h1);
    bw(OFF_PAGE_MAP, 32'h4);
    bw(OFF_PAGE_CTRL, 32'h201);
    check({31'h0, mode_on}, 32'h1);
    rchk(OFF_ACTIVE_MAP, 32'h4);
    page_check(1'b1, 16'h0004);
    // wrong length, every supported bit, clearing a set bit
    for (int i = 0; i < 3; i++)
    begin
      bw(OFF_IRQ_STAT, 32'h7);
      bw(OFF_PAGE_MAP, i == 0 ? 32'hc : (i == 1 ? SUP : 32'h0));
      bw(OFF_PAGE_CTRL, i == 0 ? 32'h301 : 32'h201);
      rchk(OFF_IRQ_STAT, 32'h6);
      rchk(OFF_ACTIVE_MAP, 32'h4);
      bus_op(1'b0, OFF_STAT, 32'h0, rd);
      check({rd[31:16], rd[11:8], rd[2:1]}, 32'h00000997);
    end
    bw(OFF_IRQ_MASK, 32'h1);
    check({31'h0, irq}, 32'h0);
    scan(32'd30, 32'd4);
    sense(SK_ABORTED, 8'h11, 8'h03, 32'd32, 32'd47);
    check({31'h0, irq}, 32'h1);
    unpred_at <= 32'd103;
    scan(32'd98, 32'd4);
    sense(SK_ABORTED, 8'h11, 8'h03, 32'd100, 32'd103);
    unpred_at <= 32'd201;
    scan(32'd200, 32'd2);
    sense(SK_MEDIUM, 8'h11, 8'h00, 32'd201, 32'h0);
    bw(OFF_IRQ_MASK, 32'h0);
    scan(32'd0, 32'd8);
    sense(SK_NONE, 8'h00, 8'h00, 32'h0, 32'h0);
    rchk(OFF_IRQ_STAT, 32'h1);
    check({31'h0, irq}, 32'h0);
    bw(OFF_IRQ_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    bw(OFF_IRQ_STAT, 32'h1);
    check({31'h0, irq}, 32'h0);
    // disable page: its map field must be ignored
    bw(OFF_PAGE_MAP, SUP);
    bw(OFF_PAGE_CTRL, 32'h200);
    check({31'h0, mode_on}, 32'h0);
    rchk(OFF_ACTIVE_MAP, 32'h0);
    page_check(1'b0, 16'h0);
    scan(32'd30, 32'd4);
    sense(SK_NONE, 8'h00, 8'h00, 32'h0, 32'h0);
    // clock enable low freezes a scan in flight at lba 501
    bw(OFF_LBA, 32'd500);
    bw(OFF_CNT, 32'd8);
    bw(OFF_CTRL, 32'h1);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    check(lba_query, 32'd501);
    check({31'h0, query_valid}, 32'h1);
    ce <= 1'b1;
    repeat (20) @(posedge clk);
    sense(SK_NONE, 8'h00, 8'h00, 32'h0, 32'h0);
    tally_and_finish();
  end
endmodule // tb_rebuild_assist_reporting
`default_nettype wire
